// File: design/fpm_flag_pin_mux.v
// flag pin direction and polarity mux with its two configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "fpm_flag_map.vh"
module fpm_flag_pin_mux #(
	parameter PIN_N = `FPM_PIN_N,
	parameter BUS_W = `FPM_BUS_W,
	parameter FILTER_CYCLES = `FPM_FILTER_CYCLES
) (
	input wire ref_clk,
	input wire resetn,
	input wire clk_en,
	input wire [`FPM_ADDR_W-1:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [`FPM_DATA_W-1:0] reg_wdata,
	output reg [`FPM_DATA_W-1:0] reg_rdata_q,
	input wire [`FPM_SRC_N-1:0] flag_source_sel,
	input wire [BUS_W-1:0] channel_flags_1,
	input wire [BUS_W-1:0] channel_flags_2,
	input wire [PIN_N-1:0] pin_in,
	output reg [PIN_N-1:0] pin_out_q,
	output reg [PIN_N-1:0] pin_oe_q,
	output reg [PIN_N-1:0] pin_is_flag_q,
	output reg [`FPM_TRIG_N-1:0] trigger_active_q,
	output reg [BUS_W-1:0] flag_bus_q
);
	reg [PIN_N-1:0] direction_q;
	reg [PIN_N-1:0] polarity_q;
	reg [PIN_N-1:0] direction_d;
	reg [PIN_N-1:0] polarity_d;
	reg [`FPM_DATA_W-1:0] rdata_d;
	reg [PIN_N-1:0] pin_out_d;
	reg [PIN_N-1:0] pin_oe_d;
	reg [BUS_W-1:0] flag_bus_d;
	reg [`FPM_TRIG_N-1:0] trigger_active_d;
	wire [BUS_W-1:0] int_flags;
	wire [PIN_N-1:0] routed;
	wire [PIN_N-1:0] pin_filt;
	wire [`FPM_TRIG_N-1:0] trigger_sense;
	wire wr_direction;
	wire wr_polarity;
	integer i;

	// role of a pin-routed element, decoded from its source and direction bits
	localparam [1:0] ROLE_NORMAL = 2'h0;
	localparam [1:0] ROLE_OUTPUT = 2'h1;
	localparam [1:0] ROLE_INPUT = 2'h2;

	// register decode for the write path; the read path decodes with a case on reg_addr
	function hit;
		input [`FPM_ADDR_W-1:0] addr;
		input [`FPM_ADDR_W-1:0] ofs;
		begin
			hit = (addr == ofs);
		end
	endfunction

	// widen a 13-bit field to the register width, upper bits as zero
	function [`FPM_DATA_W-1:0] widen;
		input [PIN_N-1:0] field;
		begin
			widen = {{(`FPM_DATA_W-PIN_N){1'b0}}, field};
		end
	endfunction

	// source select wins over direction, so a stale direction bit never drives a pin
	function [1:0] pin_role;
		input src_bit;
		input dir_bit;
		begin
			if (!src_bit) begin
				pin_role = ROLE_NORMAL;
			end else if (!dir_bit) begin
				pin_role = ROLE_OUTPUT;
			end else begin
				pin_role = ROLE_INPUT;
			end
		end
	endfunction

	assign int_flags = channel_flags_1 & channel_flags_2;

	// general pins are always routed, the selectable ones follow the source register
	assign routed = {flag_source_sel, 3'b111};

	// polarity bits of the trigger pins double as their activity sense
	assign trigger_sense = polarity_q[`FPM_IDX_TRIGGER_PIN_6:`FPM_IDX_TRIGGER_PIN_1];

	assign wr_direction = reg_wr && hit(reg_addr, `FPM_OFS_DIRECTION);
	assign wr_polarity = reg_wr && hit(reg_addr, `FPM_OFS_POLARITY);

	// every pin is filtered; only input-role elements read the result
	fpm_glitch_filter #(
		.WIDTH(PIN_N),
		.CYCLES(FILTER_CYCLES)
	) u_filter (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.raw_in(pin_in),
		.filt_q(pin_filt)
	);

	always @* begin
		direction_d = direction_q;
		polarity_d = polarity_q;
		if (wr_direction) begin
			direction_d = reg_wdata[PIN_N-1:0];
		end
		if (wr_polarity) begin
			polarity_d = reg_wdata[PIN_N-1:0];
		end
	end

	always @* begin
		rdata_d = reg_rdata_q;
		if (reg_rd) begin
			case (reg_addr)
				`FPM_OFS_DIRECTION: begin
					rdata_d = widen(direction_q);
				end
				`FPM_OFS_POLARITY: begin
					rdata_d = widen(polarity_q);
				end
				default: begin
					// unmapped addresses read as zero
					rdata_d = {`FPM_DATA_W{1'b0}};
				end
			endcase
		end
	end

	always @* begin
		// the three top elements never meet a pin and carry channel-to-channel data
		flag_bus_d = int_flags;
		pin_out_d = {PIN_N{1'b0}};
		pin_oe_d = {PIN_N{1'b0}};
		for (i = 0; i < PIN_N; i = i + 1) begin
			case (pin_role(routed[i], direction_q[i]))
				ROLE_NORMAL: begin
					// normal function: direction and polarity are ignored here
					flag_bus_d[i] = int_flags[i];
				end
				ROLE_OUTPUT: begin
					// polarity acts on the pin side, the bus keeps the combined flag
					pin_out_d[i] = int_flags[i] ^ polarity_q[i];
					pin_oe_d[i] = 1'b1;
					flag_bus_d[i] = int_flags[i];
				end
				ROLE_INPUT: begin
					flag_bus_d[i] = pin_filt[i] ^ polarity_q[i];
				end
				default: begin
					flag_bus_d[i] = int_flags[i];
				end
			endcase
		end
	end

	always @* begin
		trigger_active_d = {`FPM_TRIG_N{1'b0}};
		for (i = 0; i < `FPM_TRIG_N; i = i + 1) begin
			// only meaningful while the trigger pin keeps its normal role
			if (!routed[`FPM_IDX_TRIGGER_PIN_1+i]) begin
				trigger_active_d[i] = pin_in[`FPM_IDX_TRIGGER_PIN_1+i] ^ trigger_sense[i];
			end
		end
	end

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			direction_q <= `FPM_RST_DIRECTION;
		end else if (clk_en) begin
			direction_q <= direction_d;
		end
	end

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			polarity_q <= `FPM_RST_POLARITY;
		end else if (clk_en) begin
			polarity_q <= polarity_d;
		end
	end

	// read data holds between reads so a slow reader may sample it late
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata_q <= {`FPM_DATA_W{1'b0}};
		end else if (clk_en) begin
			reg_rdata_q <= rdata_d;
		end
	end

	// outputs are registered; a pin changes one cycle after its cause
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pin_out_q <= {PIN_N{1'b0}};
			pin_oe_q <= {PIN_N{1'b0}};
			pin_is_flag_q <= {PIN_N{1'b0}};
			trigger_active_q <= {`FPM_TRIG_N{1'b0}};
			flag_bus_q <= {BUS_W{1'b0}};
		end else if (clk_en) begin
			pin_out_q <= pin_out_d;
			pin_oe_q <= pin_oe_d;
			pin_is_flag_q <= routed;
			trigger_active_q <= trigger_active_d;
			flag_bus_q <= flag_bus_d;
		end
	end
endmodule // fpm_flag_pin_mux
`default_nettype wire

// File: design/fpm_flag_map.vh
// register offsets, field positions, reset values and timing counts of the flag pin mux
`ifndef FPM_FLAG_MAP_VH
`define FPM_FLAG_MAP_VH

`define FPM_ADDR_W 9
`define FPM_DATA_W 16
`define FPM_PIN_N 13
`define FPM_BUS_W 16

`define FPM_OFS_DIRECTION 9'h1c1
`define FPM_OFS_POLARITY 9'h1c2

`define FPM_RST_DIRECTION 13'h1fff
`define FPM_RST_POLARITY 13'h0000

// flag bus element of each pin
`define FPM_IDX_GENERAL_PIN_0 0
`define FPM_IDX_GENERAL_PIN_1 1
`define FPM_IDX_GENERAL_PIN_2 2
`define FPM_IDX_TRIGGER_PIN_1 3
`define FPM_IDX_TRIGGER_PIN_6 8
`define FPM_IDX_INTERRUPT_OUT_PIN 9
`define FPM_IDX_AMPLIFIER_OUT_PIN_1 10
`define FPM_IDX_AMPLIFIER_OUT_PIN_2 11
`define FPM_IDX_DEBUG_PIN 12

// elements 0..2 are pin only, 3..12 have a source select
`define FPM_SRC_LO 3
`define FPM_SRC_N 10
`define FPM_TRIG_N 6

// anti-glitch filter length in system clock cycles
`define FPM_FILTER_CYCLES 3

`endif

// File: design/fpm_glitch_filter.v
// per-bit anti-glitch filter: output follows input once it has been stable for a set number of cycles
`timescale 1ns/1ps
`default_nettype none
module fpm_glitch_filter #(
	parameter WIDTH = 13,
	parameter CYCLES = 3
) (
	input wire ref_clk,
	input wire resetn,
	input wire clk_en,
	input wire [WIDTH-1:0] raw_in,
	output reg [WIDTH-1:0] filt_q
);
	reg [WIDTH*CYCLES-1:0] hist_q;
	integer b;
	integer k;
	reg all_one;
	reg all_zero;
	reg [WIDTH-1:0] filt_d;

	always @* begin
		filt_d = filt_q;
		all_one = 1'b1;
		all_zero = 1'b1;
		for (b = 0; b < WIDTH; b = b + 1) begin
			all_one = 1'b1;
			all_zero = 1'b1;
			for (k = 0; k < CYCLES; k = k + 1) begin
				all_one = all_one & hist_q[k*WIDTH+b];
				all_zero = all_zero & ~hist_q[k*WIDTH+b];
			end
			// a level shorter than the window leaves the output where it was
			if (all_one) begin
				filt_d[b] = 1'b1;
			end else if (all_zero) begin
				filt_d[b] = 1'b0;
			end
		end
	end

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			hist_q <= {WIDTH*CYCLES{1'b0}};
			filt_q <= {WIDTH{1'b0}};
		end else if (clk_en) begin
			hist_q <= {hist_q[WIDTH*(CYCLES-1)-1:0], raw_in};
			filt_q <= filt_d;
		end
	end
endmodule // fpm_glitch_filter
`default_nettype wire

// File: tb/fpm_chk.sv
// port assertions for the flag pin mux
`timescale 1ns/1ps
`default_nettype none
module fpm_chk #(parameter PIN_N = 13, parameter BUS_W = 16) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic [9:0] flag_source_sel,
	input wire logic [BUS_W-1:0] channel_flags_1,
	input wire logic [BUS_W-1:0] channel_flags_2,
	input wire logic [15:0] reg_rdata_q,
	input wire logic [PIN_N-1:0] pin_oe_q,
	input wire logic [PIN_N-1:0] pin_is_flag_q,
	input wire logic [5:0] trigger_active_q,
	input wire logic [BUS_W-1:0] flag_bus_q
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	wire [BUS_W-1:0] fl = channel_flags_1 & channel_flags_2;
	logic v_q;
	// outputs follow inputs only after an enabled edge outside reset
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			v_q <= 1'b0;
		else
			v_q <= clk_en;
	end
	property p_int; v_q |-> flag_bus_q[15:13] == $past(fl[15:13]); endproperty
	a_int: assert property (p_int) else $error("bus top bits");
	property p_pin; v_q |-> pin_is_flag_q[2:0] == 3'h7; endproperty
	a_pin: assert property (p_pin) else $error("low pins not flags");
	property p_sel; v_q |-> pin_is_flag_q[12:3] == $past(flag_source_sel); endproperty
	a_sel: assert property (p_sel) else $error("flag mode");
	property p_nb; v_q |-> ((flag_bus_q[12:3] ^ $past(fl[12:3])) & ~$past(flag_source_sel)) == '0; endproperty
	a_nb: assert property (p_nb) else $error("normal bus");
	property p_noe; v_q |-> (pin_oe_q[12:3] & ~$past(flag_source_sel)) == '0; endproperty
	a_noe: assert property (p_noe) else $error("normal pin driven");
	property p_ob; v_q |-> ((flag_bus_q[12:0] ^ $past(fl[12:0])) & pin_oe_q) == '0; endproperty
	a_ob: assert property (p_ob) else $error("output flag bus");
	property p_trg; v_q |-> (trigger_active_q & $past(flag_source_sel[5:0])) == '0; endproperty
	a_trg: assert property (p_trg) else $error("trigger in flag mode");
	property p_rsv; reg_rdata_q[15:13] == 3'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits");
endmodule // fpm_chk
bind fpm_flag_pin_mux fpm_chk #(.PIN_N(PIN_N), .BUS_W(BUS_W)) u_chk(.ref_clk, .resetn, .clk_en, .flag_source_sel,
	.channel_flags_1, .channel_flags_2, .reg_rdata_q, .pin_oe_q, .pin_is_flag_q, .trigger_active_q, .flag_bus_q);
`default_nettype wire

// File: tb/fpm_pin_env.sv
// external pins: driven pins read back, others follow the bench
`timescale 1ns/1ps
`default_nettype none
module fpm_pin_env (
	input wire logic [12:0] pin_out,
	input wire logic [12:0] pin_oe,
	input wire logic [12:0] ext,
	output logic [12:0] pin_in
);
	assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule // fpm_pin_env
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the flag pin mux
`timescale 1ns/1ps
`default_nettype none
`include "fpm_flag_map.vh"
module tb_top;
	logic ref_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, clk_en = 1;
	logic [8:0] reg_addr = '0;
	logic [15:0] reg_wdata = '0, c1 = '0, c2 = '0, dir, pol, reg_rdata_q, flag_bus_q;
	logic [12:0] ext = '0, pin_in, pin_out_q, pin_oe_q, pin_is_flag_q;
	logic [9:0] src = '0;
	logic [5:0] trigger_active_q;
	logic [8:0] pad;
	integer seed = 29810, mismatches = 0, n_tests = 0, i;
	always #2 ref_clk = ~ref_clk;
	fpm_flag_pin_mux DUT(.ref_clk, .resetn, .clk_en, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_q,
		.flag_source_sel(src), .channel_flags_1(c1), .channel_flags_2(c2), .pin_in, .pin_out_q, .pin_oe_q,
		.pin_is_flag_q, .trigger_active_q, .flag_bus_q);
	fpm_pin_env u_env(.pin_out(pin_out_q), .pin_oe(pin_oe_q), .ext, .pin_in);
	task chk(input [15:0] got, input [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task acc(input w, input [8:0] a, input [15:0] d);
		@(posedge ref_clk);
		#1 reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = d;
		@(posedge ref_clk);
		#1 reg_wr = 0;
		reg_rd = 0;
		if (!w)
			chk(reg_rdata_q, d);
	endtask
	// waits for the input filter to settle, then compares against the model
	task cmp;
		integer k;
		reg [15:0] fl, eb;
		reg [12:0] eo, eoe, ef;
		reg [5:0] et;
		reg s;
		repeat (6) @(posedge ref_clk);
		#1 fl = c1 & c2;
		eb = fl;
		{eo, eoe, ef, et} = '0;
		for (k = 0; k < 13; k++) begin
			s = k < 3 ? 1'b1 : src[k-3];
			ef[k] = s;
			if (!s && k > 2 && k < 9)
				et[k-3] = ext[k] ^ pol[k];
			if (s && !dir[k]) begin
				eoe[k] = 1'b1;
				eo[k] = fl[k] ^ pol[k];
			end
			if (s && dir[k])
				eb[k] = ext[k] ^ pol[k];
		end
		chk(flag_bus_q, eb);
		chk({3'h0, pin_out_q}, {3'h0, eo});
		chk({3'h0, pin_oe_q}, {3'h0, eoe});
		chk({3'h0, pin_is_flag_q}, {3'h0, ef});
		chk({10'h000, trigger_active_q}, {10'h000, et});
	endtask
	task conclude;
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#20000;
		mismatches++;
		conclude();
	end
	initial begin
		repeat (3) @(posedge ref_clk);
		#1 resetn = 1;
		acc(0, `FPM_OFS_DIRECTION, 16'h1fff);
		acc(0, `FPM_OFS_POLARITY, 16'h0000);
		acc(1, 9'h1c0, 16'hffff);
		acc(0, 9'h1c0, 16'h0000);
		dir = 16'h1fff;
		pol = 16'h0000;
		src = 10'h3ff;
		cmp();
		// a two-cycle pulse on every input flag must not reach the bus
		ext = 13'h1fff;
		repeat (2) begin
			@(posedge ref_clk);
			#1 chk(flag_bus_q, 16'h0000);
		end
		ext = '0;
		repeat (3) begin
			@(posedge ref_clk);
			#1 chk(flag_bus_q, 16'h0000);
		end
		cmp();
		// a level held for the whole window shows after the filter and the output register
		ext = 13'h1fff;
		repeat (`FPM_FILTER_CYCLES + 1) @(posedge ref_clk);
		#1 chk(flag_bus_q, 16'h0000);
		@(posedge ref_clk);
		#1 chk(flag_bus_q, 16'h1fff);
		// a low clock enable freezes the outputs and drops register writes
		clk_en = 0;
		c1 = 16'hffff;
		c2 = 16'hffff;
		acc(1, `FPM_OFS_POLARITY, 16'h1fff);
		chk(flag_bus_q, 16'h1fff);
		clk_en = 1;
		acc(0, `FPM_OFS_POLARITY, 16'h0000);
		for (i = 0; i < 40; i++) begin
			{dir, pol} = $random(seed);
			acc(1, `FPM_OFS_DIRECTION, dir);
			acc(1, `FPM_OFS_POLARITY, pol);
			acc(0, `FPM_OFS_DIRECTION, dir & 16'h1fff);
			acc(0, `FPM_OFS_POLARITY, pol & 16'h1fff);
			{c1, c2} = $random(seed);
			{src, ext, pad} = $random(seed);
			cmp();
		end
		conclude();
	end
endmodule // tb_top
`default_nettype wire
